/* lecp_pkg.sv */
// Constants, register map and state types of the lamp effect and coupling PWM block
package lecp_pkg;
	// ----------------------------------------
	// Clock and timebase
	// ----------------------------------------
	localparam int CLK_HZ       = 125_000_000;
	localparam int T_BASE_US    = 1000;
	localparam int BASE_CYC     = CLK_HZ / 1_000_000 * T_BASE_US;
	localparam int T_FLASH_MS   = 5;
	localparam int T_SLOW_MS    = 100;
	localparam int PWM_SLOW_HZ  = 156;
	localparam int PWM_FAST_HZ  = 24_000;
	localparam int PWM_STEPS    = 256;
	localparam int PWM_SLOW_DIV = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
	localparam int PWM_FAST_DIV = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
	localparam int PRE_W        = 12;
	localparam logic [2:0] MS5_LAST   = 3'(T_FLASH_MS - 1);
	localparam logic [6:0] MS100_LAST = 7'(T_SLOW_MS - 1);
	// Durations in 100 ms ticks, and random seed
	localparam logic [7:0] SMOKE_BOOST_T = 8'h14;
	localparam logic [7:0] SHUNT_STOP_T  = 8'h05;
	localparam logic [7:0] SEC_TICKS     = 8'h0A;
	localparam logic [15:0] LFSR_SEED    = 16'hACE1;

	// ----------------------------------------
	// Register offsets (configuration numbers)
	// ----------------------------------------
	localparam logic [9:0] CV_BANK_LO   = 10'h01F;
	localparam logic [9:0] CV_BANK_HI   = 10'h020;
	localparam logic [9:0] CV_OUT_CFG   = 10'h032;
	localparam logic [9:0] CV_DIM_LIGHT = 10'h074;
	localparam logic [9:0] CV_DIM_AUX1  = 10'h075;
	localparam logic [9:0] CV_DIM_AUX2  = 10'h076;
	localparam logic [9:0] CV_CP_REP    = 10'h07C;
	localparam logic [9:0] CV_CP_PULL   = 10'h07D;
	localparam logic [9:0] CV_CP_HOLD   = 10'h07E;
	localparam logic [9:0] CV_CP_OFF    = 10'h07F;
	localparam logic [9:0] CV_CP_HDUTY  = 10'h080;
	localparam logic [9:0] CV_CP_SEL    = 10'h081;
	localparam logic [9:0] CV_SM_CFG    = 10'h082;
	localparam logic [9:0] CV_SM_THR    = 10'h083;
	localparam logic [9:0] CV_SM_TRAV   = 10'h084;
	localparam logic [9:0] CV_SM_STAND  = 10'h085;
	localparam logic [9:0] CV_SH_SPEED  = 10'h087;
	localparam logic [9:0] CV_SH_PUSH   = 10'h088;
	localparam logic [9:0] CV_SH_BACK   = 10'h089;
	localparam logic [9:0] CV_CRV_LIGHT = 10'h0AA;
	localparam logic [9:0] CV_CRV_AUX1  = 10'h0AB;
	localparam logic [9:0] CV_CRV_AUX2  = 10'h0AC;
	localparam logic [9:0] CV_CRV_PER   = 10'h0B2;
	localparam logic [9:0] CV_CRV_PHASE = 10'h0B3;
	localparam logic [9:0] CV_X_HOLD    = 10'h0B4;
	localparam logic [9:0] CV_FLK_SEL   = 10'h0B5;
	localparam logic [9:0] CV_FLK_PAT   = 10'h0B6;
	localparam logic [9:0] CV_TUBE_SEL  = 10'h0BC;
	localparam logic [9:0] CV_TUBE_INT  = 10'h0BD;
	localparam logic [9:0] CV_TUBE_MAX  = 10'h0BE;
	localparam logic [9:0] CURVE_FIRST  = 10'h101;
	localparam logic [9:0] CURVE_LAST   = 10'h200;

	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int FAST_BIT     = 3;
	localparam int GRADE_CROSSING_FLAG_BIT    = 7;
	localparam int FLK_FULL_BIT = 7;
	localparam logic [7:0] BANK_LO_VAL = 8'h08;
	localparam logic [7:0] BANK_A      = 8'h03;
	localparam logic [7:0] BANK_B      = 8'h04;
	localparam logic [7:0] CP_A1       = 8'h02;
	localparam logic [7:0] CP_A2       = 8'h04;
	localparam logic [7:0] CP_BOTH     = 8'h06;
	localparam logic [7:0] DUTY_FULL   = 8'hFF;
	localparam logic [7:0] DUTY_OFF    = 8'h00;

	// ----------------------------------------
	// State types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SM_STAND = 2'b00, SM_DELAY = 2'b01, SM_BOOST = 2'b10, SM_RUN = 2'b11
	} lecp_smoke_t;
	typedef enum logic [1:0] {
		CP_IDLE = 2'b00, CP_PULL = 2'b01, CP_HOLDS = 2'b10, CP_OFFS = 2'b11
	} lecp_cpl_t;
	typedef enum logic [1:0] {
		SH_IDLE = 2'b00, SH_PUSH = 2'b01, SH_STOP = 2'b10, SH_BACK = 2'b11
	} lecp_shunt_t;
endpackage

/* lecp_pwm.sv */
// One PWM output channel with selectable base frequency
`timescale 1ns/100ps
`default_nettype none
module lecp_pwm
	import lecp_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Control
	input  wire logic       i_fast,
	input  wire logic [7:0] i_duty,
	// Output
	output logic            o_pwm
);
	logic [PRE_W-1:0] pre_r;
	logic [7:0]       step_r;
	logic [PRE_W-1:0] pre_last;

	// Step length picks 156 Hz or 24 kHz
	assign pre_last = i_fast ? PRE_W'(PWM_FAST_DIV - 1) : PRE_W'(PWM_SLOW_DIV - 1);

	// Prescaler and 256-step ramp
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pre_r  <= '0;
			step_r <= 8'h00;
		end else if (pre_r >= pre_last) begin
			pre_r  <= '0;
			step_r <= step_r + 8'h01;
		end else begin
			pre_r <= pre_r + PRE_W'(1);
		end
	end

	// Compare, full duty stays solid
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pwm <= 1'b0;
		end else begin
			o_pwm <= (i_duty == DUTY_FULL) || (step_r < i_duty);
		end
	end
endmodule
`default_nettype wire

/* lecp_top.sv */
// Lamp effect, smoke, coupler and uncoupling engine of the decoder outputs
//
// Contract
// - Tube start effect on lights, aux one, aux two by values 1, 2, 4.
// - Tube switch-on flashes random 1 to max count, spaced interval times 5 ms.
// - Random flicker on lights, aux one, aux two by values 1, 2, 4.
// - Flicker rhythm from low nibble, brightness variation from bits 4 to 6.
// - Pattern bit 128 makes flicker base full brightness.
// - Smoke uses standstill duty, travel duty, and 100% at start.
// - Hold loco up to 15 s at 100% smoke, then boost, then travel.
// - Load rising past threshold gives another 100% boost.
// - Smoke output select in low bits, each 16 adds one second delay.
// - All outputs PWM at 156 Hz, or 24 kHz with config bit 3.
// - Coupler pulls at dimming duty, then holds at hold duty, then off.
// - Coupler sequence repeats, off time between, zero off time disables.
// - Coupler on aux one for 2, aux two for 4, both for 6.
// - Uncoupling starts only when enabled, triggered and speed step zero.
// - Push reversed, stop, back off same step, stop with direction restored.
// - Uncoupling speed, push time and back-off time from their registers.
// - 64 curve samples play cyclically, period setting times 64 ms.
// - Bank pointers 8 and 3 or 4 open curve banks at 257-512.
// - Each bank holds four 64-sample curves, samples 0 to 63.
// - Curve 1 to 8 chosen per light, aux one, aux two.
// - Phase bits shift rear, aux one, aux two playback by half period.
// - Crossing bit keeps output on until flag, then effect plus hold time.
// - Normal dimming duty per output group from its own register.
`timescale 1ns/100ps
`default_nettype none
module lecp_top
	import lecp_pkg::*;
#(
	parameter int TICK_CYC = BASE_CYC
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Configuration access
	input  wire logic       i_cv_we,
	input  wire logic       i_cv_re,
	input  wire logic [9:0] i_cv_addr,
	input  wire logic [7:0] i_cv_wdata,
	output logic [7:0]      o_cv_rdata,
	// Function and drive state
	input  wire logic       i_front_on,
	input  wire logic       i_rear_on,
	input  wire logic       i_aux_one_on,
	input  wire logic       i_aux_two_on,
	input  wire logic       i_dir_fwd,
	input  wire logic [7:0] i_speed_step,
	input  wire logic [6:0] i_load,
	input  wire logic       i_grade_crossing_flag,
	// Outputs
	output logic            o_front_light_output,
	output logic            o_rear_light_output,
	output logic            o_aux_output_one,
	output logic            o_aux_output_two,
	output logic            o_motor_hold,
	output logic            o_shunt_active,
	output logic            o_shunt_dir_fwd,
	output logic [7:0]      o_shunt_speed
);
	localparam int TW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

	// ----------------------------------------
	// Configuration store and curve memory
	// ----------------------------------------
	logic [7:0] cv_r [0:255];
	logic [5:0] crv_r [0:511];
	logic       bank_ok;
	logic       crv_hit;
	logic [9:0] crv_off;

	function automatic logic mapped(input logic [9:0] a);
		return a inside {CV_BANK_LO, CV_BANK_HI, CV_OUT_CFG, CV_DIM_LIGHT, CV_DIM_AUX1,
			CV_DIM_AUX2, CV_CP_REP, CV_CP_PULL, CV_CP_HOLD, CV_CP_OFF, CV_CP_HDUTY,
			CV_CP_SEL, CV_SM_CFG, CV_SM_THR, CV_SM_TRAV, CV_SM_STAND, CV_SH_SPEED,
			CV_SH_PUSH, CV_SH_BACK, CV_CRV_LIGHT, CV_CRV_AUX1, CV_CRV_AUX2, CV_CRV_PER,
			CV_CRV_PHASE, CV_X_HOLD, CV_FLK_SEL, CV_FLK_PAT, CV_TUBE_SEL, CV_TUBE_INT,
			CV_TUBE_MAX};
	endfunction

	// Bank window open only for pointer pairs 8/3 and 8/4
	assign bank_ok = (cv_r[CV_BANK_LO[7:0]] == BANK_LO_VAL) &&
		(cv_r[CV_BANK_HI[7:0]] == BANK_A || cv_r[CV_BANK_HI[7:0]] == BANK_B);
	assign crv_hit = bank_ok && i_cv_addr >= CURVE_FIRST && i_cv_addr <= CURVE_LAST;
	assign crv_off = i_cv_addr - CURVE_FIRST;

	// Register writes
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int k = 0; k < 256; k++) begin
				cv_r[k] <= 8'h00;
			end
		end else if (i_cv_we && mapped(i_cv_addr)) begin
			cv_r[i_cv_addr[7:0]] <= i_cv_wdata;
		end
	end

	// Curve sample writes, bank B is the upper half
	always_ff @(posedge i_clk) begin
		if (i_cv_we && crv_hit) begin
			crv_r[{cv_r[CV_BANK_HI[7:0]] == BANK_B, crv_off[7:0]}] <= i_cv_wdata[5:0];
		end
	end

	// Registered read data, unmapped reads zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cv_rdata <= 8'h00;
		end else if (i_cv_re) begin
			if (mapped(i_cv_addr)) begin
				o_cv_rdata <= cv_r[i_cv_addr[7:0]];
			end else if (crv_hit) begin
				o_cv_rdata <= {2'b00, crv_r[{cv_r[CV_BANK_HI[7:0]] == BANK_B, crv_off[7:0]}]};
			end else begin
				o_cv_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Timebase and random source
	// ----------------------------------------
	logic [TW-1:0] pre_r;
	logic [2:0]    ms5_r;
	logic [6:0]    ms100_r;
	logic          t1;
	logic          t5;
	logic          t100;
	logic [15:0]   lfsr_r;

	assign t1   = (pre_r == TW'(TICK_CYC - 1));
	assign t5   = t1 && (ms5_r == MS5_LAST);
	assign t100 = t1 && (ms100_r == MS100_LAST);

	// Millisecond, 5 ms and 100 ms ticks
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pre_r   <= '0;
			ms5_r   <= 3'h0;
			ms100_r <= 7'h00;
		end else begin
			pre_r <= t1 ? '0 : pre_r + TW'(1);
			if (t1) begin
				ms5_r   <= (ms5_r == MS5_LAST) ? 3'h0 : ms5_r + 3'h1;
				ms100_r <= (ms100_r == MS100_LAST) ? 7'h00 : ms100_r + 7'h01;
			end
		end
	end

	// Free-running pseudo-random generator
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			lfsr_r <= LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end
	end

	// ----------------------------------------
	// Smoke control
	// ----------------------------------------
	lecp_smoke_t sm_r;
	logic [7:0]  sm_cnt_r;
	logic [6:0]  load_prev_r;
	logic        moving;
	logic        sm_en;
	logic        load_up;
	logic [7:0]  sm_dly;
	logic [7:0]  sm_duty;
	logic [7:0]  sm_cfg;

	assign sm_cfg  = cv_r[CV_SM_CFG[7:0]];
	assign moving  = |i_speed_step;
	assign sm_en   = |sm_cfg[1:0];
	assign sm_dly  = {4'h0, sm_cfg[7:4]} * SEC_TICKS;
	assign load_up = (i_load > cv_r[CV_SM_THR[7:0]][6:0]) &&
		!(load_prev_r > cv_r[CV_SM_THR[7:0]][6:0]);

	// Starting delay, boost and travel
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sm_r        <= SM_STAND;
			sm_cnt_r    <= 8'h00;
			load_prev_r <= 7'h00;
		end else begin
			load_prev_r <= i_load;
			sm_cnt_r    <= t100 ? sm_cnt_r + 8'h01 : sm_cnt_r;
			unique case (sm_r)
				SM_STAND: begin
					sm_cnt_r <= 8'h00;
					if (moving && sm_en) begin
						sm_r <= (sm_dly != 8'h00) ? SM_DELAY : SM_BOOST;
					end
				end
				SM_DELAY: begin
					if (!moving) begin
						sm_r <= SM_STAND;
					end else if (sm_cnt_r >= sm_dly) begin
						sm_r     <= SM_BOOST;
						sm_cnt_r <= 8'h00;
					end
				end
				SM_BOOST: begin
					if (!moving) begin
						sm_r <= SM_STAND;
					end else if (sm_cnt_r >= SMOKE_BOOST_T) begin
						sm_r <= SM_RUN;
					end
				end
				SM_RUN: begin
					sm_cnt_r <= 8'h00;
					if (!moving) begin
						sm_r <= SM_STAND;
					end else if (load_up) begin
						sm_r <= SM_BOOST;
					end
				end
			endcase
		end
	end

	// Smoke duty per phase
	always_comb begin
		unique case (sm_r)
			SM_STAND: sm_duty = cv_r[CV_SM_STAND[7:0]];
			SM_RUN:   sm_duty = cv_r[CV_SM_TRAV[7:0]];
			default:  sm_duty = DUTY_FULL;
		endcase
	end
	assign o_motor_hold = (sm_r == SM_DELAY);

	// ----------------------------------------
	// Coupler and automatic uncoupling
	// ----------------------------------------
	lecp_cpl_t   cp_r;
	lecp_shunt_t sh_r;
	logic [7:0]  cp_cnt_r;
	logic [7:0]  cp_rep_r;
	logic [7:0]  sh_cnt_r;
	logic        sh_orig_r;
	logic [1:0]  aux_prev_r;
	logic [1:0]  cp_sel;
	logic        cp_en;
	logic        trig;
	logic        sh_go;
	logic        sh_to_back;
	logic        cp_go;
	logic [7:0]  cpv;

	assign cpv    = cv_r[CV_CP_SEL[7:0]];
	assign cp_sel = {cpv == CP_A2 || cpv == CP_BOTH, cpv == CP_A1 || cpv == CP_BOTH};
	assign cp_en  = (cv_r[CV_CP_OFF[7:0]] != 8'h00) && (|cp_sel);
	assign trig   = |(cp_sel & {i_aux_two_on, i_aux_one_on} & ~aux_prev_r);
	assign sh_go  = trig && cp_en && (i_speed_step == 8'h00) && (sh_r == SH_IDLE) &&
		(cp_r == CP_IDLE) && (cv_r[CV_SH_SPEED[7:0]] != 8'h00);
	assign sh_to_back = (sh_r == SH_STOP) && (sh_cnt_r >= SHUNT_STOP_T);
	assign cp_go  = (trig && cp_en && !sh_go && sh_r == SH_IDLE) || sh_to_back;

	// Pull, hold, off and repeat sequence
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cp_r       <= CP_IDLE;
			cp_cnt_r   <= 8'h00;
			cp_rep_r   <= 8'h00;
			aux_prev_r <= 2'b00;
		end else begin
			aux_prev_r <= {i_aux_two_on, i_aux_one_on};
			cp_cnt_r   <= t100 ? cp_cnt_r + 8'h01 : cp_cnt_r;
			unique case (cp_r)
				CP_IDLE: begin
					cp_cnt_r <= 8'h00;
					if (cp_go) begin
						cp_r     <= CP_PULL;
						cp_rep_r <= (cv_r[CV_CP_REP[7:0]] == 8'h00) ? 8'h00 : cv_r[CV_CP_REP[7:0]] - 8'h01;
					end
				end
				CP_PULL: begin
					if (cp_cnt_r >= cv_r[CV_CP_PULL[7:0]]) begin
						cp_r     <= CP_HOLDS;
						cp_cnt_r <= 8'h00;
					end
				end
				CP_HOLDS: begin
					if (cp_cnt_r >= cv_r[CV_CP_HOLD[7:0]]) begin
						cp_r     <= CP_OFFS;
						cp_cnt_r <= 8'h00;
					end
				end
				CP_OFFS: begin
					if (cp_cnt_r >= cv_r[CV_CP_OFF[7:0]]) begin
						cp_cnt_r <= 8'h00;
						if (cp_rep_r != 8'h00) begin
							cp_r     <= CP_PULL;
							cp_rep_r <= cp_rep_r - 8'h01;
						end else begin
							cp_r <= CP_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Push, stop and back-off shunting
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sh_r      <= SH_IDLE;
			sh_cnt_r  <= 8'h00;
			sh_orig_r <= 1'b0;
		end else begin
			sh_cnt_r <= t100 ? sh_cnt_r + 8'h01 : sh_cnt_r;
			unique case (sh_r)
				SH_IDLE: begin
					sh_cnt_r <= 8'h00;
					if (sh_go) begin
						sh_r      <= SH_PUSH;
						sh_orig_r <= i_dir_fwd;
					end
				end
				SH_PUSH: begin
					if (sh_cnt_r >= cv_r[CV_SH_PUSH[7:0]]) begin
						sh_r     <= SH_STOP;
						sh_cnt_r <= 8'h00;
					end
				end
				SH_STOP: begin
					if (sh_to_back) begin
						sh_r     <= SH_BACK;
						sh_cnt_r <= 8'h00;
					end
				end
				SH_BACK: begin
					if (sh_cnt_r >= cv_r[CV_SH_BACK[7:0]]) begin
						sh_r <= SH_IDLE;
					end
				end
			endcase
		end
	end

	// Motion command during shunting
	assign o_shunt_active  = (sh_r != SH_IDLE);
	assign o_shunt_dir_fwd = (sh_r == SH_PUSH) ? !sh_orig_r : sh_orig_r;
	assign o_shunt_speed   = (sh_r == SH_PUSH || sh_r == SH_BACK) ? cv_r[CV_SH_SPEED[7:0]] : 8'h00;

	// ----------------------------------------
	// Per group tube, flicker and crossing state
	// ----------------------------------------
	logic [2:0] gon;
	logic [2:0] gon_prev_r;
	logic [7:0] tb_left_r [3];
	logic [7:0] tb_cnt_r [3];
	logic [2:0] tb_ph_r;
	logic [7:0] flk_off_r [3];
	logic [3:0] flk_cnt_r [3];
	logic [7:0] xh_r [3];
	logic       x_prev_r;
	logic [2:0] xact;
	logic [7:0] dim [3];
	logic [7:0] flk_duty [3];

	assign gon = {i_aux_two_on, i_aux_one_on, i_front_on | i_rear_on};

	// Crossing flag and switch-on history
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			x_prev_r   <= 1'b0;
			gon_prev_r <= 3'b000;
		end else begin
			x_prev_r   <= i_grade_crossing_flag;
			gon_prev_r <= gon;
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_grp
		logic [7:0]  rnd;
		logic [15:0] tprod;
		logic [15:0] fprod;
		logic [7:0]  tint;
		logic [3:0]  frhy;

		assign dim[g] = cv_r[8'(CV_DIM_LIGHT + 10'(g))];
		assign rnd    = lfsr_r[g*4 +: 8];
		assign tprod  = rnd * cv_r[CV_TUBE_MAX[7:0]];
		assign fprod  = rnd * {1'b0, cv_r[CV_FLK_PAT[7:0]][6:4], 4'h0};
		assign tint   = (cv_r[CV_TUBE_INT[7:0]] == 8'h00) ? 8'h01 : cv_r[CV_TUBE_INT[7:0]];
		assign frhy   = (cv_r[CV_FLK_PAT[7:0]][3:0] == 4'h0) ? 4'h1 : cv_r[CV_FLK_PAT[7:0]][3:0];
		assign xact[g] = i_grade_crossing_flag || (xh_r[g] != 8'h00);
		assign flk_duty[g] = (cv_r[CV_FLK_PAT[7:0]][FLK_FULL_BIT] ? DUTY_FULL : dim[g]) - flk_off_r[g];

		// Tube flashes after switch-on
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				tb_left_r[g] <= 8'h00;
				tb_cnt_r[g]  <= 8'h00;
				tb_ph_r[g]   <= 1'b0;
			end else if (!gon[g]) begin
				tb_left_r[g] <= 8'h00;
			end else if (!gon_prev_r[g] && cv_r[CV_TUBE_SEL[7:0]][g] &&
				cv_r[CV_TUBE_MAX[7:0]] != 8'h00) begin
				tb_left_r[g] <= tprod[15:8] + 8'h01;
				tb_cnt_r[g]  <= 8'h00;
				tb_ph_r[g]   <= 1'b1;
			end else if (t5 && tb_left_r[g] != 8'h00) begin
				if (tb_cnt_r[g] + 8'h01 >= tint) begin
					tb_cnt_r[g] <= 8'h00;
					tb_ph_r[g]  <= !tb_ph_r[g];
					if (tb_ph_r[g]) begin
						tb_left_r[g] <= tb_left_r[g] - 8'h01;
					end
				end else begin
					tb_cnt_r[g] <= tb_cnt_r[g] + 8'h01;
				end
			end
		end

		// Flicker offset refresh every rhythm step
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				flk_off_r[g] <= 8'h00;
				flk_cnt_r[g] <= 4'h0;
			end else if (t5) begin
				if (flk_cnt_r[g] + 4'h1 >= frhy) begin
					flk_cnt_r[g] <= 4'h0;
					flk_off_r[g] <= fprod[15:8];
				end else begin
					flk_cnt_r[g] <= flk_cnt_r[g] + 4'h1;
				end
			end
		end

		// Crossing hold after flag clears
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				xh_r[g] <= 8'h00;
			end else if (x_prev_r && !i_grade_crossing_flag) begin
				xh_r[g] <= cv_r[CV_X_HOLD[7:0]];
			end else if (t100 && xh_r[g] != 8'h00) begin
				xh_r[g] <= xh_r[g] - 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Curve playback position
	// ----------------------------------------
	logic [7:0] cstep_r;
	logic [5:0] cidx_r;

	// One sample per period-setting milliseconds
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cstep_r <= 8'h00;
			cidx_r  <= 6'h00;
		end else if (t1 && cv_r[CV_CRV_PER[7:0]] != 8'h00) begin
			if (cstep_r + 8'h01 >= cv_r[CV_CRV_PER[7:0]]) begin
				cstep_r <= 8'h00;
				cidx_r  <= cidx_r + 6'h01;
			end else begin
				cstep_r <= cstep_r + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Output channels
	// ----------------------------------------
	logic [3:0] fon;
	logic [3:0] phs;
	logic [3:0] pwm;

	assign fon = {i_aux_two_on, i_aux_one_on, i_rear_on, i_front_on};
	assign phs = {cv_r[CV_CRV_PHASE[7:0]][2:0], 1'b0};

	for (genvar c = 0; c < 4; c++) begin : g_ch
		localparam int G = (c < 2) ? 0 : c - 1;
		localparam int GA = (c < 2) ? 0 : c - 2;
		logic [7:0] csel;
		logic [3:0] cnum;
		logic       cvalid;
		logic [8:0] caddr;
		logic [5:0] samp;
		logic       cp_own;
		logic       sm_own;
		logic [7:0] duty_nxt;
		logic [7:0] duty_r;

		assign csel   = cv_r[8'(CV_CRV_LIGHT + 10'(G))];
		assign cnum   = csel[3:0] - 4'h1;
		assign cvalid = (csel[3:0] != 4'h0) && (csel[3:0] <= 4'h8);
		assign caddr  = {cnum[2:0], cidx_r ^ {phs[c], 5'h00}};
		assign samp   = crv_r[caddr];
		assign cp_own = (c >= 2) && cp_en && cp_sel[GA];
		assign sm_own = (c >= 2) && sm_cfg[GA];

		// Effect priority per channel
		always_comb begin
			if (cp_own) begin
				unique case (cp_r)
					CP_PULL:  duty_nxt = dim[G];
					CP_HOLDS: duty_nxt = cv_r[CV_CP_HDUTY[7:0]];
					default:  duty_nxt = DUTY_OFF;
				endcase
			end else if (!fon[c]) begin
				duty_nxt = DUTY_OFF;
			end else if (sm_own) begin
				duty_nxt = sm_duty;
			end else if (tb_left_r[G] != 8'h00) begin
				duty_nxt = tb_ph_r[G] ? dim[G] : DUTY_OFF;
			end else if (cvalid && csel[GRADE_CROSSING_FLAG_BIT] && !xact[G]) begin
				duty_nxt = dim[G];
			end else if (cvalid) begin
				duty_nxt = {samp, samp[5:4]};
			end else if (cv_r[CV_FLK_SEL[7:0]][G]) begin
				duty_nxt = flk_duty[G];
			end else begin
				duty_nxt = dim[G];
			end
		end

		// Duty register
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				duty_r <= DUTY_OFF;
			end else begin
				duty_r <= duty_nxt;
			end
		end

		lecp_pwm u_pwm (
			.i_clk  (i_clk),
			.i_rst  (i_rst),
			.i_fast (cv_r[CV_OUT_CFG[7:0]][FAST_BIT]),
			.i_duty (duty_r),
			.o_pwm  (pwm[c])
		);
	end

	assign o_front_light_output = pwm[0];
	assign o_rear_light_output  = pwm[1];
	assign o_aux_output_one     = pwm[2];
	assign o_aux_output_two     = pwm[3];
endmodule
`default_nettype wire

/* lecp_asserts.sv */
// Port checker of the lamp effect and coupling engine
`timescale 1ns/100ps
`default_nettype none
module lecp_asserts (
	// Watched ports
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_cv_re,
	input wire logic [9:0] i_cv_addr,
	input wire logic       i_dir_fwd,
	input wire logic [7:0] i_speed_step,
	input wire logic [7:0] o_cv_rdata,
	input wire logic       o_shunt_active,
	input wire logic       o_shunt_dir_fwd,
	input wire logic [7:0] o_shunt_speed
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Shunting move steps
	sequence s_stop; (o_shunt_active && o_shunt_speed == 8'h00) [*8]; endsequence
	property p_go; $rose(o_shunt_active) |-> $past(i_speed_step) == 8'h00; endproperty
	a_go: assert property (p_go) else $error("shunt while moving");
	property p_dir; $rose(o_shunt_active) |-> o_shunt_dir_fwd != $past(i_dir_fwd); endproperty
	a_dir: assert property (p_dir) else $error("push direction");
	property p_spd; $rose(o_shunt_active) |-> o_shunt_speed != 8'h00; endproperty
	a_spd: assert property (p_spd) else $error("push speed");
	property p_own; o_shunt_speed != 8'h00 |-> o_shunt_active; endproperty
	a_own: assert property (p_own) else $error("stray speed");
	property p_halt; $fell(|o_shunt_speed) && o_shunt_active |-> s_stop; endproperty
	a_halt: assert property (p_halt) else $error("short stop");
	property p_end; $fell(o_shunt_active) && !$past(i_rst) |-> $past(o_shunt_speed) != 8'h00; endproperty
	a_end: assert property (p_end) else $error("no back-off");
	// Configuration reads
	property p_rd; i_cv_re && i_cv_addr == 10'h3FF |=> o_cv_rdata == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("unmapped read");
	property p_keep; !i_cv_re |=> $stable(o_cv_rdata); endproperty
	a_keep: assert property (p_keep) else $error("read data moved");
endmodule
bind lecp_top lecp_asserts u_chk (.*);
`default_nettype wire

/* lecp_lamps.sv */
// Lamp and coupler coil loads on the decoder outputs
`timescale 1ns/100ps
`default_nettype none
module lecp_lamps (
	// Clock and window clear
	input  wire logic   i_clk,
	input  wire logic   i_clr,
	// Driven outputs
	input  wire logic   i_lamp,
	input  wire logic   i_coil,
	// Clocks of drive since the last clear
	output logic [15:0] o_lamp_hi,
	output logic [15:0] o_coil_hi
);
	// Heat taken up by filament and coil
	always_ff @(posedge i_clk) begin
		o_lamp_hi <= i_clr ? 16'h0000 : o_lamp_hi + 16'(i_lamp);
		o_coil_hi <= i_clr ? 16'h0000 : o_coil_hi + 16'(i_coil);
	end
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking bench of the lamp effect and coupling engine
`timescale 1ns/100ps
`default_nettype none
module tb
	import lecp_pkg::*;
;
	// Design ports, loads and bookkeeping
	logic i_clk = 0, i_rst = 1, i_cv_we = 0, i_cv_re = 0, i_front_on = 0, i_rear_on = 0, clr = 1;
	logic i_aux_one_on = 0, i_aux_two_on = 0, i_dir_fwd = 1, i_grade_crossing_flag = 0, o_motor_hold;
	logic o_front_light_output, o_rear_light_output, o_aux_output_one, o_aux_output_two;
	logic o_shunt_active, o_shunt_dir_fwd;
	logic [9:0] i_cv_addr = 0;
	logic [7:0] i_cv_wdata = 0, i_speed_step = 0, o_cv_rdata, o_shunt_speed, d, v;
	logic [6:0] i_load = 0;
	logic [15:0] lamp_hi, coil_hi;
	logic [17:0] cfg [11] = '{18'h0_7C01, 18'h0_7D08, 18'h0_7E01, 18'h0_7F01, 18'h0_8000, 18'h0_8102,
		18'h0_75FF, 18'h0_8707, 18'h0_8802, 18'h0_8902, 18'h0_3208};
	int errors = 0, check_count = 0, seed = 32'h2e0c_e653, cyc = 0;
	lecp_top #(.TICK_CYC(10)) dut (.*);
	lecp_lamps u_load (.i_clk(i_clk), .i_clr(clr), .i_lamp(o_front_light_output), .i_coil(o_aux_output_one),
		.o_lamp_hi(lamp_hi), .o_coil_hi(coil_hi));
	// Clock and run limit
	always #4 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc++;
		if (cyc > 100000) begin
			errors++;
			end_sim();
		end
	end
	// Compare, bus cycle, duty window, verdict
	task automatic chk(input string n, input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic cv(input logic [9:0] a, input logic [7:0] w, input logic wr);
		@(posedge i_clk);
		i_cv_we <= wr;
		i_cv_re <= !wr;
		i_cv_addr <= a;
		i_cv_wdata <= w;
		@(posedge i_clk);
		i_cv_we <= 0;
		i_cv_re <= 0;
		@(posedge i_clk);
		#1 d = o_cv_rdata;
	endtask
	task automatic win(input int n);
		clr <= 1;
		@(posedge i_clk);
		clr <= 0;
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	function automatic logic [15:0] hi_exp(input logic [7:0] du);
		return du == DUTY_FULL ? 16'(PWM_STEPS * PWM_FAST_DIV) : 16'(du * PWM_FAST_DIV);
	endfunction
	task automatic end_sim();
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (6) @(posedge i_clk);
		i_rst <= 0;
		foreach (cfg[k]) begin
			cv(cfg[k][17:8], 0, 0);
			chk("reset value", d, 0);
			v = 8'($random(seed));
			cv(cfg[k][17:8], v, 1);
			cv(cfg[k][17:8], 0, 0);
			chk("read back", d, v);
			cv(cfg[k][17:8], cfg[k][7:0], 1);
		end
		cv(10'h3FF, 0, 0);
		chk("unmapped", d, 0);
		cv(CURVE_LAST, v, 1);
		cv(CURVE_LAST, 0, 0);
		chk("closed bank", d, 0);
		cv(CV_BANK_LO, BANK_LO_VAL, 1);
		cv(CV_BANK_HI, BANK_A, 1);
		cv(CURVE_LAST, v, 1);
		cv(CURVE_LAST, 0, 0);
		chk("curve sample", d, {2'b00, v[5:0]});
		// Light duty at the fast rate, then light off
		for (int k = 0; k < 3; k++) begin
			v = k == 0 ? DUTY_FULL : 8'($random(seed));
			cv(CV_DIM_LIGHT, v, 1);
			i_front_on <= k < 2;
			repeat (5200) @(posedge i_clk);
			win(5120);
			chk("light duty", lamp_hi, k < 2 ? hi_exp(v) : 16'h0000);
		end
		// Coupler run while moving, so no shunting move
		i_speed_step <= 8'h05;
		i_aux_one_on <= 1;
		@(posedge i_clk);
		i_aux_one_on <= 0;
		repeat (5200) @(posedge i_clk);
		win(1600);
		chk("coil pull", coil_hi, 1600);
		chk("moving shunt", o_shunt_active, 0);
		repeat (7000) @(posedge i_clk);
		win(1600);
		chk("coil off", coil_hi, 0);
		// Shunting move at standstill
		i_speed_step <= 8'h00;
		i_aux_one_on <= 1;
		@(posedge i_clk);
		i_aux_one_on <= 0;
		win(3);
		chk("push dir", o_shunt_dir_fwd, 0);
		chk("push speed", o_shunt_speed, 8'h07);
		repeat (2500) @(posedge i_clk);
		for (int k = 0; k < 6000 && o_shunt_speed === 8'h00; k++) begin
			@(posedge i_clk);
			#1;
		end
		win(1);
		chk("back-off dir", o_shunt_dir_fwd, 1);
		chk("back-off speed", o_shunt_speed, 8'h07);
		repeat (3000) @(posedge i_clk);
		win(1);
		chk("shunt done", o_shunt_active, 0);
		// Smoke on aux one with one second starting delay
		cv(CV_SM_CFG, 8'h11, 1);
		i_speed_step <= 8'h03;
		win(2);
		chk("motor hold", o_motor_hold, 1);
		win(11000);
		chk("hold released", o_motor_hold, 0);
		end_sim();
	end
endmodule
`default_nettype wire
